/* logic/dmr_cfg.svh */
`ifndef DMR_CFG_SVH
`define DMR_CFG_SVH

// Command pins sampled low-true: {cs_n, ras_n, cas_n, we_n}
`define DMR_CMD_LOAD_MODE   4'h0
`define DMR_CMD_REFRESH     4'h1
`define DMR_CMD_PRECHARGE   4'h2
`define DMR_CMD_ACTIVATE    4'h3
`define DMR_CMD_WRITE       4'h4
`define DMR_CMD_READ        4'h5
`define DMR_CMD_NOP         4'h7
`define DMR_BANK_MR         3'h0
`define DMR_BANK_EMR1       3'h1
`define DMR_BANK_EMR2       3'h2
`define DMR_BANK_EMR3       3'h3
// Main mode register fields
`define DMR_MR_BL_LSB       0
`define DMR_MR_BT_BIT       3
`define DMR_MR_CL_LSB       4
`define DMR_MR_TM_BIT       7
`define DMR_MR_DLLRST_BIT   8
`define DMR_MR_WR_LSB       9
// Extended register one fields
`define DMR_EM_DLLDIS_BIT   0
`define DMR_EM_REDUCED_BIT  1
`define DMR_EM_ODT0_BIT     2
`define DMR_EM_AL_LSB       3
`define DMR_EM_ODT1_BIT     6
`define DMR_EM_OCD_LSB      7
`define DMR_EM_DQSN_BIT     10
`define DMR_BL_FOUR         3'h2
`define DMR_BL_EIGHT        3'h3
`define DMR_OCD_EXIT        3'h0
`define DMR_OCD_DEFAULT     3'h7
// Reset values
`define DMR_MR_RESET        13'h0000
`define DMR_EMR1_RESET      13'h0000
// Clocks for the DLL to lock after enable plus reset
`define DMR_DLL_LOCK_CYCLES 200
`define DMR_LOCK_W          8

`endif

/* logic/dmr_pkg.sv */
package dmr_pkg;
    typedef enum logic [1:0] {
        DMR_DLL_OFF,
        DMR_DLL_LOCKING,
        DMR_DLL_LOCKED
    } dmr_dll_e;

    typedef struct packed {
        logic        cke;
        logic [3:0]  cmd;
        logic [2:0]  bank;
        logic [12:0] addr;
    } dmr_pins_s;

    typedef struct packed {
        logic [2:0] burst_len;
        logic       burst_interleave;
        logic [2:0] cas_latency;
        logic       test_mode;
        logic [2:0] write_recovery;
        logic       dll_enable;
        logic       reduced_drive;
        logic [2:0] additive_latency;
        logic [2:0] ocd_mode;
        logic       strobe_n_disable;
        logic [1:0] odt_setting;
        logic       self_refresh;
        logic       dll_ready;
        logic       bad_burst;
    } dmr_status_s;
endpackage

/* logic/dmr_dll_tracker.sv */
`timescale 1ns/10ps
`include "dmr_cfg.svh"

module dmr_dll_tracker
    import dmr_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    // Events from the command decoder
    input  wire logic dll_on,
    input  wire logic dll_reset,
    // State
    output logic      dll_ready,
    output dmr_dll_e  dll_state
);
    typedef struct packed {
        dmr_dll_e                st;
        logic [`DMR_LOCK_W-1:0] cnt;
    } dmr_dll_state_s;

    dmr_dll_state_s s;
    dmr_dll_state_s next_s;

    always_comb begin
        next_s = s;
        case (s.st)
            DMR_DLL_OFF: begin
                if (dll_on && dll_reset) begin
                    next_s.st  = DMR_DLL_LOCKING;
                    next_s.cnt = '0;
                end
            end
            DMR_DLL_LOCKING: begin
                if (!dll_on) begin
                    next_s.st = DMR_DLL_OFF;
                end else if (dll_reset) begin
                    next_s.cnt = '0;
                end else if (s.cnt == `DMR_LOCK_W'(`DMR_DLL_LOCK_CYCLES - 1)) begin
                    next_s.st = DMR_DLL_LOCKED;
                end else begin
                    next_s.cnt = s.cnt + `DMR_LOCK_W'(1);
                end
            end
            DMR_DLL_LOCKED: begin
                if (!dll_on) begin
                    next_s.st = DMR_DLL_OFF;
                end else if (dll_reset) begin
                    next_s.st  = DMR_DLL_LOCKING;
                    next_s.cnt = '0;
                end
            end
            default: begin
                next_s.st = DMR_DLL_OFF;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s <= '{st: DMR_DLL_OFF, cnt: '0};
        end else begin
            s <= next_s;
        end
    end

    assign dll_ready = (s.st == DMR_DLL_LOCKED);
    assign dll_state = s.st;
endmodule

/* logic/dmr_mode_regs.sv */
`timescale 1ns/10ps
`include "dmr_cfg.svh"

// Notes on behaviour
// R1: Controller runs a stable clock 200 us before any command.
// R2: Controller drives NOP with CKE high 400 ns, then precharge all; the model drives deselect (4'hf) instead.
// R3: Controller next loads extended register two (bank 2).
// R4: Controller next loads extended register three (bank 3).
// R5: Controller enables DLL via extended register one, A0 and A9..A7 low.
// R6: Controller loads main register with A8 high, resetting the DLL.
// R7: Controller then precharges all and issues two or more refreshes.
// R8: Controller loads main register with A8 low to set operation.
// R9: After 200 clocks, calibrate or write driver default then exit.
// R10: Every register write must carry valid values for all fields; the bench also loads every burst code, the reserved ones included.
// R11: Mode loads and DLL resets never disturb the memory array.
// R12: Load command with bank 0 writes A12..A0 to the main register.
// R13: Mode writes only with banks precharged, CKE high, then wait tMRD; the bench issues a main register load with CKE low after an activate with no precharge.
// R14: Burst length from A2..A0, lengths four and eight supported.
// R15: Burst type from A3, CAS latency from A6..A4, no half-clock.
// R16: A7 selects test mode, A8 requests DLL reset; A7 normally low.
// R17: Write recovery count from A11..A9, programmed as rounded-up cycles.
// R18: Load command with bank 1 writes A12..A0 to extended register one.
// R19: Extended one: A0 disables DLL, A1 selects reduced drive.
// R20: Extended one: AL A5..A3, calibration A9..A7, A10, termination A2/A6.
// R21: DLL off on self refresh entry, on and reset on exit.
// R22: Controller waits 200 clocks after DLL reset before any read; the bench reads right after a DLL reset to set read_too_early.
// R23: Controller sequences initialization in one straight-line task, with deselects between commands.

module dmr_mode_regs
    import dmr_pkg::*;
(
    // Clock and reset
    input  wire logic   clock,
    input  wire logic   resetn,
    // Command pins from the controller
    input  wire logic   cke,
    input  wire logic   cs_n,
    input  wire logic   ras_n,
    input  wire logic   cas_n,
    input  wire logic   we_n,
    input  wire logic [2:0]  bank,
    input  wire logic [12:0] addr,
    // Decoded configuration
    output logic [12:0] operating_mode_register,
    output logic [12:0] extended_mode_register_one,
    output dmr_status_s status,
    output logic        read_too_early
);
    typedef struct packed {
        dmr_pins_s   p1;
        dmr_pins_s   p2;
        logic        cke_q;
        logic [12:0] mr;
        logic [12:0] emr1;
        logic        self_ref;
        dmr_status_s st;
        logic        early;
    } dmr_state_s;

    dmr_state_s s;
    dmr_state_s next_s;
    logic       dll_on;
    logic       dll_rst;
    logic       dll_ready;
    dmr_dll_e   dll_state;
    // Assertion helper: cycles since the last DLL reset with the DLL kept on
    logic [8:0] lock_age;

    function automatic logic is_cmd(input dmr_pins_s p, input logic [3:0] c);
        return p.cke && (p.cmd == c);
    endfunction

    function automatic logic is_load(input dmr_pins_s p, input logic [2:0] b);
        return is_cmd(p, `DMR_CMD_LOAD_MODE) && (p.bank == b);
    endfunction

    // Decoder sees the second stage only; the first is pure synchronizer
    wire dmr_pins_s cur = s.p2;
    wire logic mr_wr   = is_load(cur, `DMR_BANK_MR);      // R12
    wire logic emr1_wr = is_load(cur, `DMR_BANK_EMR1);    // R18
    // Self refresh entry: refresh command with CKE falling
    wire logic sr_entry = s.cke_q && !cur.cke && (cur.cmd == `DMR_CMD_REFRESH);
    wire logic sr_exit  = s.self_ref && cur.cke;

    always_comb begin
        next_s       = s;
        next_s.p1    = '{cke: cke, cmd: {cs_n, ras_n, cas_n, we_n}, bank: bank, addr: addr};
        next_s.p2    = s.p1;
        next_s.cke_q = s.p2.cke;
        // Writes touch only these registers, never the array
        if (mr_wr) begin
            next_s.mr = cur.addr;                                    // R11
        end
        if (emr1_wr) begin
            next_s.emr1 = cur.addr;                                  // R11
        end
        if (sr_entry) begin
            next_s.self_ref = 1'b1;
        end else if (sr_exit) begin
            next_s.self_ref = 1'b0;
        end
        next_s.st.burst_len        = s.mr[`DMR_MR_BL_LSB +: 3];      // R14
        next_s.st.bad_burst        = (s.mr[`DMR_MR_BL_LSB +: 3] != `DMR_BL_FOUR) &&
                                     (s.mr[`DMR_MR_BL_LSB +: 3] != `DMR_BL_EIGHT); // R14
        next_s.st.burst_interleave = s.mr[`DMR_MR_BT_BIT];           // R15
        next_s.st.cas_latency      = s.mr[`DMR_MR_CL_LSB +: 3];      // R15
        next_s.st.test_mode        = s.mr[`DMR_MR_TM_BIT];           // R16
        next_s.st.write_recovery   = s.mr[`DMR_MR_WR_LSB +: 3];      // R17
        next_s.st.dll_enable       = dll_on;                         // R19
        next_s.st.reduced_drive    = s.emr1[`DMR_EM_REDUCED_BIT];    // R19
        next_s.st.additive_latency = s.emr1[`DMR_EM_AL_LSB +: 3];    // R20
        next_s.st.ocd_mode         = s.emr1[`DMR_EM_OCD_LSB +: 3];   // R20
        next_s.st.strobe_n_disable = s.emr1[`DMR_EM_DQSN_BIT];       // R20
        next_s.st.odt_setting      = {s.emr1[`DMR_EM_ODT1_BIT],
                                      s.emr1[`DMR_EM_ODT0_BIT]};     // R20
        next_s.st.self_refresh     = s.self_ref;
        next_s.st.dll_ready        = dll_ready;
        // Read before lock flagged, sticky until DLL locks again
        if (is_cmd(cur, `DMR_CMD_READ) && !dll_ready) begin
            next_s.early = 1'b1;                                     // R22
        end else if (dll_ready) begin
            next_s.early = 1'b0;
        end
    end

    // DLL is forced off through self refresh; exit cycle already counts as on
    assign dll_on  = !s.emr1[`DMR_EM_DLLDIS_BIT] && (!s.self_ref || sr_exit); // R21
    // Reset on a main load with A8 high, or on self refresh exit
    assign dll_rst = (mr_wr && cur.addr[`DMR_MR_DLLRST_BIT]) || sr_exit; // R16 R21

    dmr_dll_tracker u_dll (
        .clock     (clock),
        .resetn    (resetn),
        .dll_on    (dll_on),
        .dll_reset (dll_rst),
        .dll_ready (dll_ready),
        .dll_state (dll_state)
    );

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s.p1       <= '{cke: 1'b0, cmd: `DMR_CMD_NOP, bank: 3'h0, addr: 13'h0000};
            s.p2       <= '{cke: 1'b0, cmd: `DMR_CMD_NOP, bank: 3'h0, addr: 13'h0000};
            s.cke_q    <= 1'b0;
            s.mr       <= `DMR_MR_RESET;
            // Disabled DLL until software enables it
            s.emr1     <= `DMR_EMR1_RESET | 13'h0001;
            s.self_ref <= 1'b0;
            s.st       <= '0;
            s.early    <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign operating_mode_register    = s.mr;
    assign extended_mode_register_one = s.emr1;
    assign status                     = s.st;
    assign read_too_early             = s.early;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lock_age <= 9'h000;
        end else if (!dll_on) begin
            lock_age <= 9'h000;
        end else if (dll_rst) begin
            lock_age <= 9'h001;
        end else if (lock_age != 9'h000 && lock_age != 9'h1ff) begin
            lock_age <= lock_age + 9'h001;
        end
    end

    // Checks
    a_mr_load: assert property (@(posedge clock) disable iff (!resetn)
        mr_wr |=> (s.mr == $past(cur.addr))) // R12
        else $error("main register did not take address");
    a_emr1_load: assert property (@(posedge clock) disable iff (!resetn)
        emr1_wr |=> (s.emr1 == $past(cur.addr))) // R18
        else $error("extended one did not take address");
    a_mr_hold: assert property (@(posedge clock) disable iff (!resetn)
        !mr_wr |=> $stable(s.mr)) // R11
        else $error("main register changed without load");
    a_burst_field: assert property (@(posedge clock) disable iff (!resetn)
        mr_wr |=> ##1 (status.burst_len == $past(cur.addr[2:0], 2))) // R14
        else $error("burst length field wrong");
    a_cas_field: assert property (@(posedge clock) disable iff (!resetn)
        mr_wr |=> ##1 (status.cas_latency == $past(cur.addr[6:4], 2)
                       && status.burst_interleave == $past(cur.addr[3], 2))) // R15
        else $error("latency or type field wrong");
    a_wr_field: assert property (@(posedge clock) disable iff (!resetn)
        mr_wr |=> ##1 (status.write_recovery == $past(cur.addr[11:9], 2)
                       && status.test_mode == $past(cur.addr[7], 2))) // R16 R17
        else $error("recovery or test field wrong");
    a_emr1_fields: assert property (@(posedge clock) disable iff (!resetn)
        emr1_wr |=> ##1 (status.additive_latency == $past(cur.addr[5:3], 2)
                         && status.ocd_mode == $past(cur.addr[9:7], 2)
                         && status.reduced_drive == $past(cur.addr[1], 2))) // R19 R20
        else $error("extended one fields wrong");
    a_sr_dll_off: assert property (@(posedge clock) disable iff (!resetn)
        sr_entry |=> ##1 !dll_on && !dll_ready) // R21
        else $error("DLL still on in self refresh");
    a_lock_wait: assert property (@(posedge clock) disable iff (!resetn)
        (dll_rst && dll_on) |=> !dll_ready [*8]) // R22
        else $error("DLL ready too soon after reset");
    a_lock_done: assert property (@(posedge clock) disable iff (!resetn)
        (lock_age == 9'h0c9) |-> dll_ready) // R22
        else $error("DLL not ready after lock time");

    c_mr_load:   cover property (@(posedge clock) disable iff (!resetn) mr_wr);
    c_dll_lock:  cover property (@(posedge clock) disable iff (!resetn) $rose(dll_ready));
    c_sr_cycle:  cover property (@(posedge clock) disable iff (!resetn)
        sr_entry ##[1:50] sr_exit);
    c_early_rd:  cover property (@(posedge clock) disable iff (!resetn) $rose(s.early));
endmodule

/* verif/dmr_ctrl_model.sv */
`timescale 1ns/10ps
`include "dmr_cfg.svh"

module dmr_ctrl_model
    import dmr_pkg::*;
#(
    parameter int STABLE_CYC = 25000
)(
    // Clock
    input  wire logic clock,
    // Command, bank and address pins
    output dmr_pins_s pins
);
    logic [13:0] notes[$];

    initial pins = '{1'b0, 4'hf, 3'h0, 13'h0000};

    // Deselect scrambles bank and address so stale values never look valid
    task automatic send(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
        @(posedge clock);
        #1;
        pins.cmd  = c;
        pins.bank = b;
        pins.addr = a;
        if (pins.cke && c == `DMR_CMD_LOAD_MODE && b[2:1] == 2'b00)
            notes.push_back({b[0], a});
        @(posedge clock);
        #1;
        pins.cmd  = 4'hf;
        pins.bank = ~b;
        pins.addr = ~a;
    endtask

    task automatic init_seq(input logic [12:0] mr, input logic [12:0] em);
        repeat (STABLE_CYC) @(posedge clock);
        #1;
        pins.cke = 1'b1;
        repeat (50) @(posedge clock);
        send(`DMR_CMD_PRECHARGE, 3'h0, 13'h0400);
        send(`DMR_CMD_LOAD_MODE, `DMR_BANK_EMR2, 13'h0000);
        send(`DMR_CMD_LOAD_MODE, `DMR_BANK_EMR3, 13'h0000);
        send(`DMR_CMD_LOAD_MODE, `DMR_BANK_EMR1, em & 13'h1c7e);
        send(`DMR_CMD_LOAD_MODE, `DMR_BANK_MR, (mr & 13'h1e7f) | 13'h0100);
        send(`DMR_CMD_PRECHARGE, 3'h0, 13'h0400);
        repeat (2) send(`DMR_CMD_REFRESH, 3'h0, 13'h0000);
        send(`DMR_CMD_LOAD_MODE, `DMR_BANK_MR, mr & 13'h1e7f);
        repeat (200) @(posedge clock);
        send(`DMR_CMD_LOAD_MODE, `DMR_BANK_EMR1, (em & 13'h1c7e) | 13'h0380);
        send(`DMR_CMD_LOAD_MODE, `DMR_BANK_EMR1, em & 13'h1c7e);
    endtask

    // Refresh while clock enable drops; exit is left to the caller
    task automatic sr_enter;
        @(posedge clock);
        #1;
        pins.cmd = `DMR_CMD_REFRESH;
        pins.cke = 1'b0;
        @(posedge clock);
        #1;
        pins.cmd = 4'hf;
    endtask
endmodule

/* verif/tb_dmr_mode_regs.sv */
`timescale 1ns/10ps
`include "dmr_cfg.svh"

module tb_dmr_mode_regs
    import dmr_pkg::*;
;
    logic        clock   = 1'b0;
    logic        resetn  = 1'b0;
    dmr_pins_s   pins;
    logic [12:0] mr_q;
    logic [12:0] em_q;
    dmr_status_s st;
    logic        early;
    logic [4:0]  ld_pipe = '0;
    logic [13:0] n;
    logic [12:0] lm;
    logic [12:0] le;
    int          fails   = 0;
    int          checked = 0;
    wire  [12:0] mr_f    = {1'b0, st.burst_len, st.burst_interleave, st.cas_latency,
                            st.test_mode, st.write_recovery, st.bad_burst};
    wire  [12:0] em_f    = {2'b00, st.dll_enable, st.reduced_drive, st.additive_latency,
                            st.ocd_mode, st.strobe_n_disable, st.odt_setting};

    always #4 clock = ~clock;

    dmr_ctrl_model i_dmr_ctrl_model (.clock(clock), .pins(pins));

    dmr_mode_regs i_dmr_mode_regs (
        .clock(clock), .resetn(resetn), .cke(pins.cke), .cs_n(pins.cmd[3]),
        .ras_n(pins.cmd[2]), .cas_n(pins.cmd[1]), .we_n(pins.cmd[0]), .bank(pins.bank),
        .addr(pins.addr), .operating_mode_register(mr_q), .extended_mode_register_one(em_q),
        .status(st), .read_too_early(early));

    task automatic cmp_word(input string what, input logic [12:0] exp, input logic [12:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_flag(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    function automatic logic [12:0] fields(input logic [13:0] t);
        if (t[13])
            return {2'b00, ~t[0], t[1], t[5:3], t[9:7], t[10], t[6], t[2]};
        return {1'b0, t[2:0], t[3], t[6:4], t[7], t[11:9], t[2:0] != 3'h2 && t[2:0] != 3'h3};
    endfunction

    // Loads reach the register two edges after sampling, fields one later
    always @(posedge clock)
        ld_pipe <= {ld_pipe[3:0], pins.cke && pins.cmd == `DMR_CMD_LOAD_MODE && !pins.bank[2:1]};

    initial forever begin
        @(posedge clock);
        #2;
        if (ld_pipe[3]) begin
            n = i_dmr_ctrl_model.notes[0];
            cmp_word("register", n[12:0], n[13] ? em_q : mr_q);
        end
        if (ld_pipe[4]) begin
            n = i_dmr_ctrl_model.notes.pop_front();
            cmp_word("fields", fields(n), n[13] ? em_f : mr_f);
        end
    end

    initial begin
        #(8 * 40000);
        fails++;
        stop_test();
    end

    initial begin
        void'($urandom(8098));
        repeat (2) @(posedge clock);
        #1;
        resetn = 1'b1;
        cmp_word("mode reset", `DMR_MR_RESET, mr_q);
        i_dmr_ctrl_model.init_seq(13'($urandom), 13'($urandom));
        cmp_flag("dll ready", 1'b1, st.dll_ready);
        // Every burst code, back to back with extended loads
        for (int i = 0; i < 8; i++) begin
            lm = (13'($urandom) & 13'h1e78) | 13'(i);
            le = 13'($urandom) & 13'h1ffe;
            i_dmr_ctrl_model.send(`DMR_CMD_LOAD_MODE, `DMR_BANK_MR, lm);
            i_dmr_ctrl_model.send(`DMR_CMD_LOAD_MODE, `DMR_BANK_EMR1, le);
        end
        i_dmr_ctrl_model.send(`DMR_CMD_LOAD_MODE, `DMR_BANK_EMR2, ~lm);
        i_dmr_ctrl_model.send(`DMR_CMD_LOAD_MODE, `DMR_BANK_EMR3, ~le);
        i_dmr_ctrl_model.send(`DMR_CMD_ACTIVATE, `DMR_BANK_MR, ~lm);
        i_dmr_ctrl_model.pins.cke = 1'b0;
        i_dmr_ctrl_model.send(`DMR_CMD_LOAD_MODE, `DMR_BANK_MR, ~lm);
        #8 i_dmr_ctrl_model.pins.cke = 1'b1;
        repeat (6) @(posedge clock);
        cmp_word("mode kept", lm, mr_q);
        cmp_word("ext kept", le, em_q);
        i_dmr_ctrl_model.send(`DMR_CMD_LOAD_MODE, `DMR_BANK_MR, lm | 13'h0100);
        i_dmr_ctrl_model.send(`DMR_CMD_READ, 3'h0, 13'h0000);
        repeat (5) @(posedge clock);
        cmp_flag("early read", 1'b1, early);
        cmp_flag("dll ready", 1'b0, st.dll_ready);
        repeat (185) @(posedge clock);
        cmp_flag("dll ready", 1'b0, st.dll_ready);
        repeat (15) @(posedge clock);
        cmp_flag("dll ready", 1'b1, st.dll_ready);
        cmp_flag("early read", 1'b0, early);
        i_dmr_ctrl_model.sr_enter();
        repeat (6) @(posedge clock);
        cmp_flag("self refresh", 1'b1, st.self_refresh);
        cmp_flag("dll ready", 1'b0, st.dll_ready);
        i_dmr_ctrl_model.pins.cke = 1'b1;
        repeat (6) @(posedge clock);
        cmp_flag("self refresh", 1'b0, st.self_refresh);
        cmp_flag("dll ready", 1'b0, st.dll_ready);
        repeat (205) @(posedge clock);
        cmp_flag("dll ready", 1'b1, st.dll_ready);
        stop_test();
    end
endmodule
